// file: rtl/trig_pkg.sv
// Constants shared by the legacy address/data match trigger.
package trig_pkg;
    localparam int XLEN = 64;
    localparam logic [11:0] ADDR_MATCH_CTRL = 12'h7a1;
    localparam logic [11:0] ADDR_COMPARE = 12'h7a2;
    localparam logic [3:0] TYPE_LEGACY = 4'h2;
    // Field positions of match_trigger_control
    localparam int POS_TYPE = 60;
    localparam int POS_DMODE = 59;
    localparam int POS_MASKMAX = 53;
    localparam int POS_SIZEHI = 21;
    localparam int POS_HIT = 20;
    localparam int POS_SELECT = 19;
    localparam int POS_TIMING = 18;
    localparam int POS_SIZELO = 16;
    localparam int POS_ACTION = 12;
    localparam int POS_CHAIN = 11;
    localparam int POS_MATCH = 7;
    localparam int POS_PRIV_M = 6;
    localparam int POS_PRIV_S = 4;
    localparam int POS_PRIV_U = 3;
    localparam int POS_EXECUTE = 2;
    localparam int POS_STORE = 1;
    localparam int POS_LOAD = 0;
    // Reset values of every trigger
    localparam logic [3:0] RST_SIZE = 4'h0;
    localparam logic [3:0] RST_ACTION = 4'h0;
    localparam logic [3:0] RST_MATCH = 4'h0;
    localparam logic RST_BIT = 1'b0;
    localparam logic [63:0] RST_COMPARE = 64'h0;
    // Legal limits
    localparam logic [3:0] SIZE_MAX_CODE = 4'h9;
    localparam logic [3:0] ACTION_MAX = 4'h1;
    localparam logic [3:0] MATCH_MAX = 4'h3;
    localparam logic [5:0] MASKMAX_LIMIT = 6'h3f;
    // Match modes
    typedef enum logic [3:0] {
        MATCH_EQUAL = 4'b0000,
        MATCH_RANGE = 4'b0001,
        MATCH_GE = 4'b0010,
        MATCH_LT = 4'b0011
    } match_mode_t;
    // Privilege codes
    localparam logic [1:0] PRIV_U = 2'h0;
    localparam logic [1:0] PRIV_S = 2'h1;
    localparam logic [1:0] PRIV_M = 2'h3;
endpackage

// file: rtl/trig_compare.sv
// One trigger's comparison of an access against its compare value.
`timescale 1ns/1ns
module trig_compare
    import trig_pkg::*;
(
    input wire logic [3:0] matchMode,
    input wire logic selectData,
    input wire logic [3:0] sizeCode,
    input wire logic [2:0] privEn,
    input wire logic [2:0] kindEn,
    input wire logic [63:0] compareValue,
    input wire logic accExec,
    input wire logic accStore,
    input wire logic accLoad,
    input wire logic [1:0] accPriv,
    input wire logic [3:0] accSize,
    input wire logic [63:0] accAddr,
    input wire logic [63:0] accData,
    output logic isMatch
);
    logic [63:0] probe; // Value under test
    logic [63:0] careMask; // Bits above the lowest zero of the compare
    logic valueOk;
    logic kindOk;
    logic privOk;
    logic sizeOk;

    // Address or data as the probe value
    always_comb
    begin
        probe = selectData ? accData : accAddr;
        careMask = ~(compareValue ^ (compareValue + 64'h1));
        case (matchMode)
            MATCH_EQUAL: valueOk = (probe == compareValue);
            MATCH_RANGE: valueOk = ((probe & careMask) ==
                                    (compareValue & careMask));
            MATCH_GE: valueOk = (probe >= compareValue);
            MATCH_LT: valueOk = (probe < compareValue);
            default: valueOk = 1'b0;
        endcase
    end

    // Access kind, privilege and size qualifiers
    always_comb
    begin
        kindOk = (kindEn[2] & accExec) | (kindEn[1] & accStore) |
                 (kindEn[0] & accLoad);
        case (accPriv)
            PRIV_M: privOk = privEn[2];
            PRIV_S: privOk = privEn[1];
            PRIV_U: privOk = privEn[0];
            default: privOk = 1'b0;
        endcase
        sizeOk = (sizeCode == 4'h0) || (sizeCode == accSize);
        isMatch = valueOk & kindOk & privOk & sizeOk;
    end
endmodule

// file: rtl/match_trigger.sv
// Legacy address/data match trigger bank with its control registers.
`timescale 1ns/1ns
module match_trigger
    import trig_pkg::*;
#(
    parameter int NUM_TRIG = 2,
    parameter int IDX_W = 1,
    parameter logic [5:0] MASK_MAX = 6'h0c,
    parameter bit HIT_IMPL = 1'b1,
    parameter bit TIMING_WRITABLE = 1'b1,
    parameter bit TIMING_FIXED = 1'b1
)
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic debugMode,
    input wire logic [IDX_W-1:0] trigIndex,
    input wire logic [11:0] csrAddr,
    input wire logic csrWrite,
    input wire logic csrRead,
    input wire logic [trig_pkg::XLEN-1:0] csrWdata,
    output logic [trig_pkg::XLEN-1:0] csrRdata,
    input wire logic accValid,
    input wire logic accExec,
    input wire logic accLoad,
    input wire logic accStore,
    input wire logic [1:0] accPriv,
    input wire logic [3:0] accSize,
    input wire logic [trig_pkg::XLEN-1:0] accAddr,
    input wire logic [trig_pkg::XLEN-1:0] accData,
    input wire logic [trig_pkg::XLEN-1:0] accPc,
    input wire logic [trig_pkg::XLEN-1:0] accNextPc,
    input wire logic [NUM_TRIG-1:0] qualOk,
    output logic suppressLoadWb,
    output logic fireValid,
    output logic fireAfter,
    output logic [3:0] fireAction,
    output logic [trig_pkg::XLEN-1:0] epcValue,
    output logic [trig_pkg::XLEN-1:0] trapValue
);
    import trig_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks, refused before any simulation starts
    if (NUM_TRIG < 1 || NUM_TRIG > (1 << IDX_W))
        $error("NUM_TRIG does not fit the selector width");
    if (MASK_MAX > MASKMAX_LIMIT)
        $error("MASK_MAX above the largest range");

    ////////////////////////////////////////////////////////////////////////
    // Per-trigger state
    logic dmodeQ [NUM_TRIG]; // Writable from debug mode only
    logic [3:0] sizeQ [NUM_TRIG]; // Combined size code
    logic hitQ [NUM_TRIG];
    logic selectQ [NUM_TRIG];
    logic timingQ [NUM_TRIG];
    logic [3:0] actionQ [NUM_TRIG];
    logic chainQ [NUM_TRIG];
    logic [3:0] matchQ [NUM_TRIG];
    logic [2:0] privQ [NUM_TRIG]; // M, S, U
    logic [2:0] kindQ [NUM_TRIG]; // Execute, store, load
    logic [63:0] compareQ [NUM_TRIG];
    logic [NUM_TRIG-1:0] rawMatch; // Value and qualifiers agree
    logic [NUM_TRIG-1:0] chainAll; // All members so far match
    logic [NUM_TRIG-1:0] fires; // Chain tail fires
    logic [NUM_TRIG-1:0] hitSet; // Member of a firing chain
    logic [NUM_TRIG-1:0] firesBefore;
    logic [NUM_TRIG-1:0] firesAfter;
    logic anyBefore;
    logic anyAfter;
    logic [3:0] actBefore;
    logic [3:0] actAfter;
    logic ctrlSel;
    logic cmpSel;
    logic canWrite;

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers
    // Keep old size when the new code is not a defined size
    function automatic logic [3:0] legalSize(input logic [3:0] nv,
                                             input logic [3:0] ov);
        legalSize = (nv <= SIZE_MAX_CODE) ? nv : ov;
    endfunction

    // Keep old match mode when unsupported; range needs MASK_MAX
    function automatic logic [3:0] legalMatch(input logic [3:0] nv,
                                              input logic [3:0] ov);
        if (nv > MATCH_MAX)
            legalMatch = ov;
        else if (nv == MATCH_RANGE && MASK_MAX == 6'h0)
            legalMatch = ov;
        else
            legalMatch = nv;
    endfunction

    // Assemble the visible control word of one trigger
    function automatic logic [63:0] packCtrl(input int i);
        logic [63:0] w;
        w = 64'h0;
        w[POS_TYPE +: 4] = TYPE_LEGACY;
        w[POS_DMODE] = dmodeQ[i];
        w[POS_MASKMAX +: 6] = MASK_MAX;
        w[POS_SIZEHI +: 2] = sizeQ[i][3:2];
        w[POS_HIT] = hitQ[i];
        w[POS_SELECT] = selectQ[i];
        w[POS_TIMING] = timingQ[i];
        w[POS_SIZELO +: 2] = sizeQ[i][1:0];
        w[POS_ACTION +: 4] = actionQ[i];
        w[POS_CHAIN] = chainQ[i];
        w[POS_MATCH +: 4] = matchQ[i];
        w[POS_PRIV_M] = privQ[i][2];
        w[POS_PRIV_S] = privQ[i][1];
        w[POS_PRIV_U] = privQ[i][0];
        w[POS_EXECUTE] = kindQ[i][2];
        w[POS_STORE] = kindQ[i][1];
        w[POS_LOAD] = kindQ[i][0];
        packCtrl = w;
    endfunction

    // Selected trigger, and dmode guards writes outside debug mode
    always_comb
    begin
        ctrlSel = (csrAddr == ADDR_MATCH_CTRL);
        cmpSel = (csrAddr == ADDR_COMPARE);
        canWrite = csrWrite &&
                   (int'(trigIndex) < NUM_TRIG) &&
                   (!dmodeQ[trigIndex] || debugMode);
    end

    ////////////////////////////////////////////////////////////////////////
    // Comparators, one per trigger
    genvar g;
    generate
        for (g = 0; g < NUM_TRIG; g = g + 1)
        begin : gen_cmp
            logic cmpHit;
            // Address for select 0, data for select 1
            trig_compare u_cmp (
                .matchMode(matchQ[g]),
                .selectData(selectQ[g]),
                .sizeCode(sizeQ[g]),
                .privEn(privQ[g]),
                .kindEn(kindQ[g]),
                .compareValue(compareQ[g]),
                .accExec(accExec),
                .accStore(accStore),
                .accLoad(accLoad),
                .accPriv(accPriv),
                .accSize(accSize),
                .accAddr(accAddr),
                .accData(accData),
                .isMatch(cmpHit)
            );
            // Every trigger stays quiet while already halted
            assign rawMatch[g] = accValid & cmpHit & qualOk[g] &
                                 ~debugMode;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Chain resolution
    // A chain fires at its tail only when every member matches and all
    // members share one timing value.
    always_comb
    begin
        for (int i = 0; i < NUM_TRIG; i++)
        begin
            if (i > 0 && chainQ[i-1])
                chainAll[i] = rawMatch[i] && chainAll[i-1] &&
                              (timingQ[i] == timingQ[i-1]);
            else
                chainAll[i] = rawMatch[i];
        end
        for (int i = 0; i < NUM_TRIG; i++)
        begin
            fires[i] = chainAll[i] && !(chainQ[i] && i < NUM_TRIG - 1);
        end
        // Hit goes to every member of a firing chain
        for (int i = NUM_TRIG - 1; i >= 0; i--)
        begin
            if (i < NUM_TRIG - 1 && chainQ[i])
                hitSet[i] = fires[i] || hitSet[i+1];
            else
                hitSet[i] = fires[i];
        end
    end

    // Split by timing, lowest index action wins
    always_comb
    begin
        anyBefore = 1'b0;
        anyAfter = 1'b0;
        actBefore = RST_ACTION;
        actAfter = RST_ACTION;
        for (int i = NUM_TRIG - 1; i >= 0; i--)
        begin
            firesBefore[i] = fires[i] && !timingQ[i];
            firesAfter[i] = fires[i] && timingQ[i];
            if (firesBefore[i])
            begin
                anyBefore = 1'b1;
                actBefore = actionQ[i];
            end
            if (firesAfter[i])
            begin
                anyAfter = 1'b1;
                actAfter = actionQ[i];
            end
        end
    end

    // Data-compare load trigger before retire: access done, no writeback
    // The memory side effects already happened; only the register write
    // is held back, and which parts of a multi-access op completed is
    // left to the pipeline.
    always_comb
    begin
        suppressLoadWb = 1'b0;
        for (int i = 0; i < NUM_TRIG; i++)
        begin
            if (firesBefore[i] && selectQ[i] && kindQ[i][0] && accLoad)
                suppressLoadWb = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register writes and hit tracking
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < NUM_TRIG; i++)
            begin
                dmodeQ[i] <= RST_BIT;
                sizeQ[i] <= RST_SIZE;
                hitQ[i] <= RST_BIT;
                selectQ[i] <= RST_BIT;
                timingQ[i] <= RST_BIT;
                actionQ[i] <= RST_ACTION;
                chainQ[i] <= RST_BIT;
                matchQ[i] <= RST_MATCH;
                privQ[i] <= 3'h0;
                kindQ[i] <= 3'h0;
                compareQ[i] <= RST_COMPARE;
            end
        end
        else
        begin
            for (int i = 0; i < NUM_TRIG; i++)
            begin
                if (canWrite && ctrlSel && int'(trigIndex) == i)
                begin
                    dmodeQ[i] <= csrWdata[POS_DMODE] & debugMode;
                    sizeQ[i] <= legalSize({csrWdata[POS_SIZEHI +: 2],
                        csrWdata[POS_SIZELO +: 2]}, sizeQ[i]);
                    selectQ[i] <= csrWdata[POS_SELECT];
                    // Fixed timing reads back the one supported value after a control write; reset loads RST_BIT
                    timingQ[i] <= TIMING_WRITABLE ? csrWdata[POS_TIMING] :
                                  TIMING_FIXED;
                    if (csrWdata[POS_ACTION +: 4] <= ACTION_MAX)
                        actionQ[i] <= csrWdata[POS_ACTION +: 4];
                    chainQ[i] <= csrWdata[POS_CHAIN];
                    matchQ[i] <= legalMatch(csrWdata[POS_MATCH +: 4],
                                            matchQ[i]);
                    privQ[i] <= {csrWdata[POS_PRIV_M], csrWdata[POS_PRIV_S],
                                 csrWdata[POS_PRIV_U]};
                    kindQ[i] <= {csrWdata[POS_EXECUTE], csrWdata[POS_STORE],
                                 csrWdata[POS_LOAD]};
                end
                if (canWrite && cmpSel && int'(trigIndex) == i)
                    compareQ[i] <= csrWdata;
                // Firing sets hit even against a same-cycle clear
                if (HIT_IMPL)
                begin
                    if (canWrite && ctrlSel && int'(trigIndex) == i)
                        hitQ[i] <= csrWdata[POS_HIT] | hitSet[i];
                    else
                        hitQ[i] <= hitQ[i] | hitSet[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read data, one cycle after the read strobe
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            csrRdata <= 64'h0;
        else if (csrRead && int'(trigIndex) < NUM_TRIG)
        begin
            if (ctrlSel)
                csrRdata <= packCtrl(int'(trigIndex));
            else if (cmpSel)
                csrRdata <= compareQ[trigIndex];
            else
                csrRdata <= 64'h0;
        end
        else if (csrRead)
            csrRdata <= 64'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Trigger action report
    // A before firing takes the instruction's own PC and suppresses any
    // simultaneous after firing, since that instruction never retires.
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fireValid <= 1'b0;
            fireAfter <= 1'b0;
            fireAction <= RST_ACTION;
            epcValue <= 64'h0;
            trapValue <= 64'h0;
        end
        else
        begin
            fireValid <= anyBefore | anyAfter;
            fireAfter <= anyAfter & ~anyBefore;
            if (anyBefore)
            begin
                fireAction <= actBefore;
                epcValue <= accPc;
                trapValue <= accAddr;
            end
            else if (anyAfter)
            begin
                fireAction <= actAfter;
                epcValue <= accNextPc;
                trapValue <= accAddr;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence beforeFire_s;
        anyBefore;
    endsequence

    sequence afterOnly_s;
        anyAfter && !anyBefore;
    endsequence

    before_pc_a: assert property (
        beforeFire_s |=> fireValid && !fireAfter && epcValue == $past(accPc))
        else $error("before firing lost the matching PC");

    after_pc_a: assert property (
        afterOnly_s |=> fireAfter && epcValue == $past(accNextPc))
        else $error("after firing lost the next PC");

    trap_value_a: assert property (
        (anyBefore || anyAfter) |=> trapValue == $past(accAddr))
        else $error("trap value is not the firing address");

    no_fire_a: assert property (
        !(anyBefore || anyAfter) |=> !fireValid)
        else $error("fire reported with no firing trigger");

    mixed_chain_a: assert property (
        (NUM_TRIG > 1 && chainQ[0] && timingQ[0] != timingQ[1])
        |-> !fires[1])
        else $error("mixed timing chain fired");

    hit_sticky_a: assert property (
        (hitSet[0] && HIT_IMPL) |=> hitQ[0])
        else $error("hit not set after firing");

    type_read_a: assert property (
        (csrRead && ctrlSel && int'(trigIndex) < NUM_TRIG)
        |=> csrRdata[POS_TYPE +: 4] == TYPE_LEGACY &&
            csrRdata[POS_MASKMAX +: 6] == MASK_MAX)
        else $error("control read shows wrong type or range");

    load_wb_a: assert property (
        suppressLoadWb |-> accLoad && anyBefore ##1 fireValid)
        else $error("writeback blocked without a before load firing");

    size_legal_a: assert property (
        sizeQ[0] <= SIZE_MAX_CODE)
        else $error("illegal size code stored");

    qual_gate_a: assert property (
        !qualOk[0] |-> !rawMatch[0] && !hitSet[0])
        else $error("trigger matched with qualifier false");
endmodule

// file: testbench/hart_access_model.sv
// Hart pipeline model that retires one access at a time.
`timescale 1ns/1ns
module hart_access_model
(
    input wire logic clk_sys,
    input wire logic suppressLoadWb,
    output logic accValid,
    output logic accExec,
    output logic accLoad,
    output logic accStore,
    output logic [1:0] accPriv,
    output logic [3:0] accSize,
    output logic [63:0] accAddr,
    output logic [63:0] accData,
    output logic [63:0] accPc,
    output logic [63:0] accNextPc
);
    // Quiet pipeline at time zero, machine privilege
    initial
    begin
        {accValid, accExec, accLoad, accStore} = 4'h0;
        accPriv = 2'h3;
        accSize = 4'h0;
        {accAddr, accData, accPc, accNextPc} = '0;
    end
    // Kind bits are execute, store, load, as in the control word
    task automatic retire(input logic [2:0] kind, input logic [3:0] size,
        input logic [63:0] addr, input logic [63:0] data,
        input logic [63:0] pc, output logic supp);
        @(negedge clk_sys);
        accValid = 1'b1;
        {accExec, accStore, accLoad} = kind;
        accSize = size;
        accAddr = addr;
        // Upper half cleared for 32-bit accesses
        accData = (size == 4'h3) ? {32'h0, data[31:0]} : data;
        accPc = pc;
        accNextPc = pc + 64'h4;
        // Writeback block is combinational, look before the edge
        #1 supp = suppressLoadWb;
        @(negedge clk_sys);
        accValid = 1'b0;
        // Released address, data and PC lines show inverted values, not a stale copy
        accAddr = ~accAddr;
        accData = ~accData;
        accPc = ~accPc;
    endtask
endmodule

// file: testbench/tb.sv
// Self-checking bench for the match trigger bank.
`timescale 1ns/1ns
module tb;
    import trig_pkg::*;
    localparam logic [5:0] MAX_RANGE = 6'h0c; // Range limit under test
    logic clk_sys, arst_n, debugMode, csrWrite, csrRead, supp;
    logic [0:0] trigIndex;
    logic [11:0] csrAddr;
    logic [63:0] csrWdata, csrRdata, rd, a, d, w;
    logic [1:0] qualOk, accPriv;
    logic [3:0] accSize, fireAction, s;
    logic suppressLoadWb, fireValid, fireAfter;
    logic accValid, accExec, accLoad, accStore;
    logic [63:0] accAddr, accData, accPc, accNextPc, epcValue, trapValue;
    int mismatches, num_checks;

    ////////////////////////////////////////////////////////////////////////
    match_trigger #(.NUM_TRIG(2), .IDX_W(1), .MASK_MAX(MAX_RANGE))
        u_match_trigger
    (
        .clk_sys(clk_sys), .arst_n(arst_n), .debugMode(debugMode),
        .trigIndex(trigIndex), .csrAddr(csrAddr), .csrWrite(csrWrite),
        .csrRead(csrRead), .csrWdata(csrWdata), .csrRdata(csrRdata),
        .accValid(accValid), .accExec(accExec), .accLoad(accLoad),
        .accStore(accStore), .accPriv(accPriv), .accSize(accSize),
        .accAddr(accAddr), .accData(accData), .accPc(accPc),
        .accNextPc(accNextPc), .qualOk(qualOk),
        .suppressLoadWb(suppressLoadWb), .fireValid(fireValid),
        .fireAfter(fireAfter), .fireAction(fireAction),
        .epcValue(epcValue), .trapValue(trapValue)
    );
    hart_access_model u_hart_access_model
    (
        .clk_sys(clk_sys), .suppressLoadWb(suppressLoadWb),
        .accValid(accValid), .accExec(accExec), .accLoad(accLoad),
        .accStore(accStore), .accPriv(accPriv), .accSize(accSize),
        .accAddr(accAddr), .accData(accData), .accPc(accPc),
        .accNextPc(accNextPc)
    );

    ////////////////////////////////////////////////////////////////////////
    // 250 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // Whole run is about 120 cycles; this is ample
    initial
    begin
        #40000;
        mismatches++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic csr_wr(input logic [11:0] ad, input logic [0:0] ix,
        input logic [63:0] dt);
        @(negedge clk_sys);
        {csrWrite, csrAddr, trigIndex, csrWdata} = {1'b1, ad, ix, dt};
        @(negedge clk_sys);
        csrWrite = 1'b0;
    endtask
    // Read data lands at the edge after the strobe
    task automatic csr_rd(input logic [11:0] ad, input logic [0:0] ix);
        @(negedge clk_sys);
        {csrRead, csrAddr, trigIndex} = {1'b1, ad, ix};
        @(negedge clk_sys);
        csrRead = 1'b0;
        rd = csrRdata;
    endtask
    // Read view: type 2, range limit, zero gap and bit 5
    function automatic logic [63:0] rdv(input logic [63:0] v);
        return {TYPE_LEGACY, 1'b0, MAX_RANGE, 30'h0, v[22:6], 1'b0, v[4:0]};
    endfunction
    // Control word with machine privilege enabled
    function automatic logic [63:0] cfg(input logic sel, tim, chn,
        input logic [3:0] act, input logic [2:0] kind);
        cfg = 64'h0;
        cfg[POS_SELECT] = sel;
        cfg[POS_TIMING] = tim;
        cfg[POS_CHAIN] = chn;
        cfg[POS_ACTION +: 4] = act;
        cfg[POS_PRIV_M] = 1'b1;
        cfg[POS_EXECUTE -: 3] = kind;
    endfunction
    // One access, then the fire report one cycle on
    task automatic fire(input logic [2:0] kind, input logic [63:0] ad, dt,
        input logic yes, tim, input logic [3:0] act);
        logic [63:0] pc;
        pc = {ad[63:2] ^ 62'h155, 2'h0};
        u_hart_access_model.retire(kind, 4'h3, ad, dt, pc, supp);
        chk("fireValid", fireValid, yes);
        if (yes)
        begin
            chk("fireAfter", fireAfter, tim);
            chk("epcValue", epcValue, tim ? pc + 64'h4 : pc);
            chk("trapValue", trapValue, ad);
            chk("fireAction", fireAction, act);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        {arst_n, debugMode, csrWrite, csrRead, trigIndex} = 5'h0;
        csrAddr = '0;
        csrWdata = '0;
        qualOk = 2'h3;
        w = $urandom(95);
        repeat (3) @(negedge clk_sys);
        arst_n = 1'b1;
        // Reset view of every trigger
        for (int i = 0; i < 2; i++)
        begin
            csr_rd(ADDR_MATCH_CTRL, i[0]);
            chk("ctrl reset", rd, rdv(64'h0));
        end
        // Random legal words, all size codes reachable
        repeat (10)
        begin
            w = {$urandom, $urandom};
            s = 4'($urandom_range(9));
            {w[22:21], w[17:16]} = s;
            w[15:7] = {3'h0, 1'($urandom_range(1)), 1'b0,
                4'($urandom_range(3))};
            csr_wr(ADDR_MATCH_CTRL, w[63], w);
            csr_rd(ADDR_MATCH_CTRL, w[63]);
            chk("ctrl rw", rd, rdv(w));
        end
        // Size code 10 is illegal, old value kept
        csr_wr(ADDR_MATCH_CTRL, w[63],
            {w[63:23], 2'b10, w[20:18], 2'b10, w[15:0]});
        csr_rd(ADDR_MATCH_CTRL, w[63]);
        chk("size kept", rd, rdv(w));
        // Address store trigger, both timings and actions
        csr_wr(ADDR_MATCH_CTRL, 1'b1, 64'h0);
        for (int t = 0; t < 2; t++)
        begin
            a = {$urandom, $urandom};
            csr_wr(ADDR_COMPARE, 1'b0, a);
            csr_rd(ADDR_COMPARE, 1'b0);
            chk("compare rw", rd, a);
            csr_wr(ADDR_MATCH_CTRL, 1'b0, cfg(0, t[0], 0, t[3:0], 3'b010));
            fire(3'b010, a ^ 64'h8, 64'h5, 1'b0, t[0], t[3:0]);
            fire(3'b010, a, 64'h5, 1'b1, t[0], t[3:0]);
            chk("supp store", supp, 1'b0);
            csr_rd(ADDR_MATCH_CTRL, 1'b0);
            chk("hit set", rd[POS_HIT], 1'b1);
        end
        csr_wr(ADDR_MATCH_CTRL, 1'b0, cfg(0, 1, 0, 4'h1, 3'b010));
        csr_rd(ADDR_MATCH_CTRL, 1'b0);
        chk("hit clear", rd[POS_HIT], 1'b0);
        // Aligned 16-byte range: low nibble of the compare is 0111
        csr_wr(ADDR_COMPARE, 1'b0, {a[63:4], 4'h7});
        csr_wr(ADDR_MATCH_CTRL, 1'b0, cfg(0, 1, 0, 4'h1, 3'b010) | 64'h80);
        fire(3'b010, {a[63:4], 4'h9}, 64'h5, 1'b1, 1'b1, 4'h1);
        fire(3'b010, a ^ 64'h10, 64'h5, 1'b0, 1'b1, 4'h1);
        // Data load: after timing tried first, then before timing
        d = {$urandom, $urandom};
        csr_wr(ADDR_COMPARE, 1'b0, {32'h0, d[31:0]});
        csr_wr(ADDR_MATCH_CTRL, 1'b0, cfg(1, 1, 0, 4'h0, 3'b001));
        fire(3'b001, a, d, 1'b1, 1'b1, 4'h0);
        chk("supp after", supp, 1'b0);
        csr_wr(ADDR_MATCH_CTRL, 1'b0, cfg(1, 0, 0, 4'h0, 3'b001));
        fire(3'b001, a, d, 1'b1, 1'b0, 4'h0);
        chk("supp load", supp, 1'b1);
        // Chain with mixed timing must stay silent
        csr_wr(ADDR_COMPARE, 1'b0, a);
        csr_wr(ADDR_COMPARE, 1'b1, a);
        csr_wr(ADDR_MATCH_CTRL, 1'b0, cfg(0, 0, 1, 4'h0, 3'b001));
        csr_wr(ADDR_MATCH_CTRL, 1'b1, cfg(0, 1, 0, 4'h0, 3'b001));
        fire(3'b001, a, 64'h0, 1'b0, 1'b0, 4'h0);
        csr_wr(ADDR_MATCH_CTRL, 1'b1, cfg(0, 0, 0, 4'h0, 3'b001));
        fire(3'b001, a, 64'h0, 1'b1, 1'b0, 4'h0);
        // Failed extra qualifier blocks the chain
        @(negedge clk_sys);
        qualOk = 2'b10;
        fire(3'b001, a, 64'h0, 1'b0, 1'b0, 4'h0);
        report_and_stop();
    end
endmodule
